// ===== ifa_fetch_accel.sv
// Instruction fetch accelerator between the core fetch port and a 32-bit burst flash.
// Assumes the flash port and the core are logic on clock_i, so no synchronisers are used;
// the flash holds no more than one request and answers with a one-cycle ack.
`timescale 1ns/1ps

// Function
// [R1] Queue prefetches ahead during idle flash cycles
// [R2] Each flash fetch carries one 32-bit word
// [R3] Miss flushes queue, refills, stalls core
// [R4] Target looked up in store before refill
// [R5] Fifteen recent targets with eight instructions each
// [R6] All entries compared at once for hit
// [R7] Hit serves store; queue restarts beyond eight
// [R8] Sixteenth entry reserved for interrupt vector read
// [R9] Literal loads never flush the queue
// [R10] Queue eight words, store fifteen entries
// [R11] Vector entry permanently holds vector-read instruction
// [R12] Full store replaces least recently taken entry
module ifa_fetch_accel
  import ifa_pkg::*;
#(
  parameter logic [31:0] VEC_ADDR = 32'hFFFF_FFF0,  // Address of the vector-read instruction.
  parameter logic [31:0] VEC_WORD = 32'hE51F_F000   // Its encoding; value is arbitrary.
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        fetch_valid_i,
  input  wire logic [31:0] fetch_addr_i,
  output logic             fetch_ready_o,
  output logic             instr_valid_o,
  output logic [31:0]      instr_data_o,
  input  wire logic        instr_ready_i,
  input  wire logic        lit_valid_i,
  input  wire logic [31:0] lit_addr_i,
  output logic             lit_ready_o,
  output logic             lit_done_o,
  output logic [31:0]      lit_data_o,
  output logic             flash_req_o,
  output logic [31:0]      flash_addr_o,
  input  wire logic        flash_ack_i,
  input  wire logic [31:0] flash_rdata_i,
  output logic             bts_hit_o
);

  // Look-ahead queue: circular store, head address and fill level.
  logic [31:0] q_mem_q [QDEPTH];
  logic [31:0] q_mem_d [QDEPTH];
  logic [2:0]  q_rd_q, q_rd_d;          // Head slot.
  logic [3:0]  q_cnt_q, q_cnt_d;        // Stored words.
  logic [31:0] q_base_q, q_base_d;      // Address of the head word.
  // Branch target store: tag, per-word valid bits, words and recency age.
  logic [31:0] tag_q [BTS_ENTRIES];
  logic [31:0] tag_d [BTS_ENTRIES];
  logic [7:0]  wv_q [BTS_ENTRIES];
  logic [7:0]  wv_d [BTS_ENTRIES];
  logic [31:0] wd_q [BTS_ENTRIES][BTS_WORDS];
  logic [31:0] wd_d [BTS_ENTRIES][BTS_WORDS];
  logic [3:0]  age_q [BTS_ENTRIES];
  logic [3:0]  age_d [BTS_ENTRIES];
  logic        fill_q, fill_d;          // An entry is being captured from a refill.
  logic [3:0]  fent_q, fent_d;          // Entry being captured.
  logic [2:0]  fidx_q, fidx_d;          // Next word slot to capture.
  // Flash port and literal path.
  ifa_fl_t     fl_q, fl_d;
  logic [31:0] fa_q, fa_d;              // Address on the flash port.
  logic        drop_q, drop_d;          // Discard the answer to a flushed prefetch.
  logic        lp_q, lp_d;              // Literal waiting for the flash.
  logic [31:0] la_q, la_d;
  logic        ld_q, ld_d;
  logic [31:0] ldat_q, ldat_d;
  // Two-entry output buffer towards the core.
  logic [31:0] b_mem_q [2];
  logic [31:0] b_mem_d [2];
  logic        b_wr_q, b_wr_d, b_rd_q, b_rd_d;
  logic [1:0]  b_cnt_q, b_cnt_d;
  logic [31:0] last_q, last_d;          // Last fetched address, for sequence detection.
  logic        hit_q, hit_d;

  // Parallel lookup of every regular entry.
  logic [BTS_ENTRIES-1:0] ehit;
  logic [31:0]            diff [BTS_ENTRIES];
  genvar g;
  generate
    for (g = 0; g < BTS_ENTRIES; g++) begin : g_cmp
      assign diff[g] = fetch_addr_i - tag_q[g];
      assign ehit[g] = (diff[g] < ENTRY_SPAN) && (diff[g][1:0] == 2'b00)
                       && wv_q[g][diff[g][4:2]];  // [R6]
    end
  endgenerate

  logic        vec_hit, q_hit, any_hit, seq, b_space;
  logic [3:0]  hidx;
  logic [31:0] hword;

  // Pick the matching entry and word; if several entries match, the highest index wins.
  always_comb begin
    hidx  = 4'h0;
    hword = 32'h0000_0000;
    for (int e = 0; e < BTS_ENTRIES; e++) begin
      if (ehit[e]) begin
        hidx  = 4'(e);
        hword = wd_q[e][diff[e][4:2]];  // [R7]
      end
    end
    vec_hit = (fetch_addr_i == VEC_ADDR);  // [R8] [R11]
    q_hit   = (q_cnt_q != 4'h0) && (fetch_addr_i == q_base_q);
    any_hit = |ehit;
    seq     = (fetch_addr_i == last_q + WORD_STEP);
    b_space = (b_cnt_q != 2'd2);
    // The core stalls until some source can supply the requested word and the output buffer has room.
    fetch_ready_o = b_space && (vec_hit || q_hit || any_hit);  // [R3]
    lit_ready_o   = !lp_q;
  end

  // Next-state logic for the whole accelerator.
  always_comb begin
    logic       push, pop, touch;
    logic [3:0] tidx, victim, tage;
    logic [31:0] bword;
    push = 1'b0; pop = 1'b0; touch = 1'b0;
    tidx = 4'h0; victim = 4'h0; tage = 4'h0; bword = 32'h0000_0000;
    q_mem_d = q_mem_q; q_rd_d = q_rd_q; q_cnt_d = q_cnt_q; q_base_d = q_base_q;
    tag_d = tag_q; wv_d = wv_q; wd_d = wd_q; age_d = age_q;
    fill_d = fill_q; fent_d = fent_q; fidx_d = fidx_q;
    fl_d = fl_q; fa_d = fa_q; drop_d = drop_q;
    lp_d = lp_q; la_d = la_q; ld_d = 1'b0; ldat_d = ldat_q;
    b_mem_d = b_mem_q; b_wr_d = b_wr_q; b_rd_d = b_rd_q; b_cnt_d = b_cnt_q;
    last_d = last_q; hit_d = 1'b0;

    // Least recently taken regular entry is the replacement victim.
    for (int e = 0; e < BTS_ENTRIES; e++) begin
      if (age_q[e] == AGE_OLDEST) begin
        victim = 4'(e);  // [R12]
      end
    end

    // A flash answer lands in the literal port or at the queue tail, or is dropped after a flush.
    if (flash_ack_i && (fl_q != FL_IDLE)) begin
      if (fl_q == FL_LIT) begin
        ldat_d = flash_rdata_i;  // [R9]
        ld_d   = 1'b1;
        lp_d   = 1'b0;
      end else if (!drop_q) begin
        q_mem_d[3'(q_rd_q + q_cnt_q[2:0])] = flash_rdata_i;  // [R2]
        q_cnt_d = q_cnt_q + 4'h1;
        // Refill words at the new target are also copied into the store.
        if (fill_q && (fa_q == tag_q[fent_q] + {27'h0, fidx_q, 2'b00})) begin
          wd_d[fent_q][fidx_q] = flash_rdata_i;  // [R5]
          wv_d[fent_q][fidx_q] = 1'b1;
          fidx_d = fidx_q + 3'h1;
          fill_d = (fidx_q != 3'h7);
        end
      end
      fl_d   = FL_IDLE;
      drop_d = 1'b0;
    end

    // Core fetch: vector entry, then sequential queue, then branch store, else refill.
    if (fetch_valid_i && fetch_ready_o) begin
      push   = 1'b1;
      last_d = fetch_addr_i;
      if (vec_hit) begin
        bword = VEC_WORD;  // [R11]
      end else if (q_hit) begin
        bword = q_mem_q[q_rd_q];  // [R1]
        pop   = 1'b1;
      end else begin
        bword = hword;
        hit_d = 1'b1;
        touch = !seq;
        tidx  = hidx;
        if (!seq) begin
          // Queue restarts just past the eight words held by the entry.
          q_cnt_d  = 4'h0;  // [R7]
          q_base_d = tag_q[hidx] + ENTRY_SPAN;
          drop_d   = (fl_d == FL_PF);
        end
      end
    end else if (fetch_valid_i && !vec_hit && !q_hit && !any_hit
                 && !(q_base_q == fetch_addr_i && q_cnt_q == 4'h0)) begin
      // Store checked first; only a true miss flushes and allocates.
      q_cnt_d  = 4'h0;  // [R4] [R3]
      q_base_d = fetch_addr_i;
      drop_d   = (fl_d == FL_PF);
      tag_d[victim] = fetch_addr_i;  // [R12]
      wv_d[victim]  = 8'h00;
      fill_d = 1'b1;
      fent_d = victim;
      fidx_d = 3'h0;
      touch  = 1'b1;
      tidx   = victim;
    end

    // Popping advances head and base together, so the prefetch address stays put.
    if (pop) begin
      q_rd_d   = q_rd_q + 3'h1;
      q_cnt_d  = q_cnt_d - 4'h1;
      q_base_d = q_base_q + WORD_STEP;
    end

    // Recency update: the taken entry becomes youngest.
    if (touch) begin
      tage = age_q[tidx];
      for (int e = 0; e < BTS_ENTRIES; e++) begin
        if (age_q[e] < tage) begin
          age_d[e] = age_q[e] + 4'h1;  // [R12]
        end
      end
      age_d[tidx] = 4'h0;
    end

    // Literal loads borrow the flash without touching queue state.
    if (lit_valid_i && !lp_q) begin
      lp_d = 1'b1;  // [R9]
      la_d = lit_addr_i;
    end

    // Issue the next flash word: literal first, else prefetch into free queue room.
    if (fl_d == FL_IDLE) begin
      if (lp_q && !ld_d) begin
        fl_d = FL_LIT;
        fa_d = la_q;
      end else if (q_cnt_d < 4'(QDEPTH)) begin
        fl_d = FL_PF;  // [R1] [R10]
        fa_d = q_base_d + {26'h0, q_cnt_d, 2'b00};
      end
    end

    // Two-entry output buffer; a stalled core loses nothing.
    if (push) begin
      b_mem_d[b_wr_q] = bword;
      b_wr_d = !b_wr_q;
    end
    if (instr_valid_o && instr_ready_i) begin
      b_rd_d = !b_rd_q;
    end
    b_cnt_d = b_cnt_q + {1'b0, push} - {1'b0, instr_valid_o && instr_ready_i};
  end

  // Registers; a drop flag cannot outlive the request it belongs to.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      q_rd_q <= 3'h0; q_cnt_q <= 4'h0; q_base_q <= RESET_ADDR;
      for (int e = 0; e < BTS_ENTRIES; e++) begin
        tag_q[e] <= 32'h0000_0000;
        wv_q[e]  <= 8'h00;
        age_q[e] <= 4'(e);
      end
      fill_q <= 1'b0; fent_q <= 4'h0; fidx_q <= 3'h0;
      fl_q <= FL_IDLE; fa_q <= 32'h0000_0000; drop_q <= 1'b0;
      lp_q <= 1'b0; la_q <= 32'h0000_0000; ld_q <= 1'b0; ldat_q <= 32'h0000_0000;
      b_wr_q <= 1'b0; b_rd_q <= 1'b0; b_cnt_q <= 2'd0;
      b_mem_q[0] <= 32'h0000_0000; b_mem_q[1] <= 32'h0000_0000;
      last_q <= 32'h0000_0000; hit_q <= 1'b0;
    end else begin
      q_rd_q <= q_rd_d; q_cnt_q <= q_cnt_d; q_base_q <= q_base_d;
      tag_q <= tag_d; wv_q <= wv_d; age_q <= age_d;
      fill_q <= fill_d; fent_q <= fent_d; fidx_q <= fidx_d;
      fl_q <= fl_d; fa_q <= fa_d; drop_q <= drop_d;
      lp_q <= lp_d; la_q <= la_d; ld_q <= ld_d; ldat_q <= ldat_d;
      b_wr_q <= b_wr_d; b_rd_q <= b_rd_d; b_cnt_q <= b_cnt_d; b_mem_q <= b_mem_d;
      last_q <= last_d; hit_q <= hit_d;
    end
  end

  // Bulk storage carries no reset; the store's validity bits and the queue fill level guard it.
  always_ff @(posedge clock_i) begin
    q_mem_q <= q_mem_d;
    wd_q    <= wd_d;
  end

  assign instr_valid_o = (b_cnt_q != 2'd0);
  assign instr_data_o  = b_mem_q[b_rd_q];
  assign lit_done_o    = ld_q;
  assign lit_data_o    = ldat_q;
  assign flash_req_o   = (fl_q != FL_IDLE);
  assign flash_addr_o  = fa_q;
  assign bts_hit_o     = hit_q;

endmodule

// ===== ifa_fetch_accel_checker.sv
// Port checker of the fetch accelerator.
// Assumes it is bound to ifa_fetch_accel on its single clock.
`timescale 1ns/1ps
module ifa_fetch_accel_checker #(
  parameter logic [31:0] VEC_ADDR = 32'hFFFF_FFF0,
  parameter logic [31:0] VEC_WORD = 32'hE51F_F000
) (
  input wire logic        clock_i,
  input wire logic        resetn_i,
  input wire logic        fetch_valid_i,
  input wire logic [31:0] fetch_addr_i,
  input wire logic        fetch_ready_o,
  input wire logic        instr_valid_o,
  input wire logic [31:0] instr_data_o,
  input wire logic        instr_ready_i,
  input wire logic        lit_valid_i,
  input wire logic        lit_ready_o,
  input wire logic        lit_done_o,
  input wire logic        flash_req_o,
  input wire logic [31:0] flash_addr_o,
  input wire logic        flash_ack_i,
  input wire logic        bts_hit_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // A literal is taken, then answered within a bounded wait.
  sequence lit_take; lit_valid_i && lit_ready_o; endsequence
  sequence lit_fin; ##[2:40] lit_done_o; endsequence
  // The flash holds one request, so address and request must stand until the answer.
  hold_req_a: assert property (flash_req_o && !flash_ack_i
    |=> flash_req_o && $stable(flash_addr_o)) else $error("flash request not held");
  lit_pulse_a: assert property (lit_done_o |=> !lit_done_o)
    else $error("literal done too long");
  lit_cause_a: assert property (lit_done_o |-> $past(flash_ack_i))
    else $error("done w/o ack");
  lit_busy_a: assert property (lit_take |=> !lit_ready_o)
    else $error("second literal open");
  lit_bound_a: assert property (lit_take |-> lit_fin) else $error("literal never done");
  vec_ready_a: assert property (fetch_valid_i && fetch_addr_i == VEC_ADDR && !instr_valid_o
    |-> fetch_ready_o) else $error("vector fetch stalled");
  vec_word_a: assert property (fetch_valid_i && fetch_ready_o && fetch_addr_i == VEC_ADDR
    && !instr_valid_o |=> instr_valid_o && instr_data_o == VEC_WORD) else $error("bad vector");
  valid_cause_a: assert property ($rose(instr_valid_o)
    |-> $past(fetch_valid_i && fetch_ready_o)) else $error("word without fetch");
  out_hold_a: assert property (instr_valid_o && !instr_ready_i |=> instr_valid_o
    && $stable(instr_data_o)) else $error("word lost in stall");
  hit_cause_a: assert property (bts_hit_o |-> $past(fetch_valid_i && fetch_ready_o))
    else $error("hit without fetch");
endmodule

// ===== ifa_fetch_accel_tb.sv
// Self-checking bench of the fetch accelerator with a flash model.
// Assumes one 25 MHz clock; the core side is driven by the tasks below.
`timescale 1ns/1ps
module ifa_fetch_accel_tb;
  localparam logic [31:0] KEY = 32'hA5A5_0F0F;  // Flash data pattern.
  localparam logic [31:0] VA  = 32'hFFFF_FFF0;  // Vector-read address.
  localparam logic [31:0] VW  = 32'h1234_5678;  // Vector word; value is arbitrary.
  logic        clock_i, resetn_i, fetch_valid_i, instr_ready_i, lit_valid_i, flash_ack_i;
  logic        fetch_ready_o, instr_valid_o, lit_ready_o, lit_done_o, flash_req_o, bts_hit_o;
  logic [31:0] fetch_addr_i, lit_addr_i, instr_data_o, lit_data_o, flash_addr_o, flash_rdata_i;
  logic [31:0] w;
  logic [3:0]  lat;
  int          fail_count, n_tests, cyc, took;
  // Kept as logic so that an unknown hit flag fails the four-state compare.
  logic        hit;
  ifa_fetch_accel #(.VEC_ADDR(VA), .VEC_WORD(VW)) ifa_fetch_accel_i (.*);
  ifa_flash_model #(.KEY(KEY)) ifa_flash_model_i (.clock_i, .resetn_i, .lat_i(lat),
    .req_i(flash_req_o), .addr_i(flash_addr_o), .ack_o(flash_ack_i), .rdata_o(flash_rdata_i));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One core fetch; returns the word, the take delay and the hit flag.
  task automatic fetch(input logic [31:0] a);
    took = 0;
    fetch_valid_i <= 1'b1;
    fetch_addr_i <= a;
    do begin
      @(posedge clock_i);
      took++;
    end while (fetch_ready_o !== 1'b1 && took < 60);
    fetch_valid_i <= 1'b0;
    @(posedge clock_i);
    hit = bts_hit_o;
    chk(instr_valid_o, 1'b1);
    w = instr_data_o;
  endtask
  task automatic t_seq;
    for (int i = 0; i < 8; i++) begin
      repeat (8) @(posedge clock_i);
      fetch(32'h100 + 4 * i);
      chk(w, (32'h100 + 4 * i) ^ KEY);
      if (i > 0) chk(took, 1);
    end
    $display("sequential test done");
  endtask
  task automatic t_branch;
    fetch(32'h200);
    chk(hit, 0);
    fetch(32'h100);
    chk(hit, 1);
    chk(took, 1);
    for (int i = 1; i < 8; i++) begin
      fetch(32'h100 + 4 * i);
      chk(took, 1);
    end
    repeat (12) @(posedge clock_i);
    fetch(32'h120);
    chk(w, 32'h120 ^ KEY);
    chk(took, 1);
    $display("branch test done");
  endtask
  task automatic t_vec;
    // A slow flash shows that the vector word never waits for it.
    lat <= 4'hF;
    fetch(VA);
    chk(w, VW);
    chk(took, 1);
    lat <= 4'h3;
    $display("vector test done");
  endtask
  task automatic t_lit;
    fetch(32'h300);
    repeat (40) @(posedge clock_i);
    lit_valid_i <= 1'b1;
    lit_addr_i <= 32'h5000;
    @(posedge clock_i);
    lit_valid_i <= 1'b0;
    // Exactly one done pulse must appear, so a lost literal is counted too.
    took = 0;
    repeat (40) begin
      @(posedge clock_i);
      if (lit_done_o === 1'b1) begin
        took++;
        chk(lit_data_o, 32'h5000 ^ KEY);
      end
    end
    chk(took, 1);
    fetch(32'h304);
    chk(took, 1);
    chk(w, 32'h304 ^ KEY);
    $display("literal test done");
  endtask
  task automatic t_evict;
    for (int k = 1; k <= 16; k++) fetch(k << 12);
    fetch(32'h1000);
    chk(hit, 0);
    fetch(32'h3000);
    chk(hit, 1);
    fetch(32'h2000);
    chk(hit, 0);
    $display("eviction test done");
  endtask
  task automatic t_stall;
    int n;
    n = 0;
    instr_ready_i <= 1'b0;
    fetch_valid_i <= 1'b1;
    fetch_addr_i <= 32'h600;
    repeat (40) begin
      @(posedge clock_i);
      if (fetch_ready_o === 1'b1) begin
        n++;
        fetch_addr_i <= 32'h600 + 4 * n;
      end
    end
    fetch_valid_i <= 1'b0;
    instr_ready_i <= 1'b1;
    chk(n, 2);
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_i);
      chk(instr_data_o, (32'h600 + 4 * i) ^ KEY);
    end
    $display("stall test done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // A run that outlives its ceiling counts as a failure.
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      conclude;
    end
  end
  initial begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end
  initial begin
    {resetn_i, fetch_valid_i, lit_valid_i, instr_ready_i} = 4'h1;
    {fetch_addr_i, lit_addr_i} = 64'h0;
    lat = 4'h3;
    repeat (2) @(posedge clock_i);
    resetn_i <= 1'b1;
    t_seq;
    t_branch;
    t_vec;
    t_lit;
    t_evict;
    t_stall;
    conclude;
  end
endmodule
bind ifa_fetch_accel ifa_fetch_accel_checker #(.VEC_ADDR(VEC_ADDR), .VEC_WORD(VEC_WORD))
  ifa_fetch_accel_checker_i (.*);

// ===== ifa_flash_model.sv
// Burst flash model: one word per request after a delay set by the bench.
// Assumes the accelerator holds request and address until the acknowledge.
`timescale 1ns/1ps
module ifa_flash_model #(
  parameter logic [31:0] KEY = 32'hA5A5_0F0F  // Pattern mixed into each address.
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  lat_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output logic             ack_o,
  output logic [31:0]      rdata_o
);
  logic [3:0] cnt_q;  // Cycles waited on the current request.
  // Data lines toggle between answers, so a stale word never looks valid.
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ack_o <= 1'b0;
      cnt_q <= 4'h0;
    end else if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      cnt_q <= 4'h0;
      rdata_o <= ~rdata_o;
    end else if (cnt_q >= lat_i) begin
      ack_o <= 1'b1;
      rdata_o <= addr_i ^ KEY;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ===== ifa_pkg.sv
// Shared constants and types of the instruction fetch accelerator.
// Assumes a single core clock domain; imported whole by the accelerator module.
package ifa_pkg;

  localparam int          QDEPTH        = 8;      // Look-ahead queue depth in words.
  localparam int          BTS_ENTRIES   = 15;     // Regular branch target store entries.
  localparam int          BTS_WORDS     = 8;      // Instructions kept per entry.
  localparam int          FLASH_MAX_MHZ = 96;     // Highest flash word fetch rate.
  localparam int          CLK_MHZ       = 25;     // Core clock rate.
  localparam logic [31:0] WORD_STEP     = 32'h0000_0004;  // Bytes per instruction word.
  localparam logic [31:0] ENTRY_SPAN    = 32'h0000_0020;  // Bytes covered by one entry.
  localparam logic [31:0] RESET_ADDR    = 32'h0000_0000;  // Queue base after reset.
  localparam logic [3:0]  AGE_OLDEST    = 4'hE;           // Age of the replacement victim.
  localparam logic [3:0]  VEC_SLOT      = 4'hF;           // Index of the interrupt entry.

  // Owner of the single outstanding flash request.
  typedef enum logic [1:0] {
    FL_IDLE = 2'b00,
    FL_PF   = 2'b01,
    FL_LIT  = 2'b10
  } ifa_fl_t;

endpackage
